// ===== hw/pif_irq.sv
// Peripheral interrupt enables, core status flags and request logic
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`include "pif_irq_consts.svh"
module pif_irq #(
    parameter int ADDR_W = 8,
    parameter int PIN_N = 8,
    parameter int PORTS = 5,
    parameter int PORT_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADDR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [`PIF_DATA_W-1:0] wb_dat_w,
    output logic [`PIF_DATA_W-1:0] wb_dat_r,
    output logic wb_ack,
    input wire logic timer0_overflow,
    input wire logic [PIN_N-1:0] gpio,
    input wire logic ext_rising_edge,
    input wire logic [PORTS*PORT_W-1:0] port_change_flags,
    input wire logic peripheral_irq_enable,
    input wire logic [`PIF_REG_W-1:0] capture_flags,
    input wire logic [`PIF_REG_W-1:0] misc_flags,
    input wire logic [`PIF_REG_W-1:0] measure_flags,
    output logic [`PIF_REG_W-1:0] capture_irq_enable,
    output logic [`PIF_REG_W-1:0] misc_irq_enable,
    output logic [`PIF_REG_W-1:0] measure_timer_irq_enable,
    output logic [`PIF_REG_W-1:0] core_irq_status,
    output logic peripheral_irq_req,
    output logic irq
);
    localparam int SEL_W = (PIN_N > 1) ? $clog2(PIN_N) : 1;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    pif_reg_if bus ();

    pif_pkg::pif_byte_type capture_irq_enable_r;
    pif_pkg::pif_byte_type misc_irq_enable_r;
    pif_pkg::pif_byte_type measure_timer_irq_enable_r;
    pif_pkg::pif_event_type irq_mask_r;
    pif_pkg::pif_event_type event_status;
    pif_pkg::pif_event_type event_set;
    pif_pkg::pif_byte_type status_v;
    pif_pkg::pif_byte_type rdata_nxt;
    logic [SEL_W-1:0] external_pin_select_r;
    logic pin_prev_r;
    logic pin_now;
    logic ext_event;
    logic change_notify_summary_flag_r;
    logic chg_prev_r;
    logic [1:0] core_flags;
    logic [1:0] core_wdata;
    logic peripheral_irq_req_r;
    logic req_prev_r;
    logic req_nxt;
    logic irq_r;
    logic wr_cap;
    logic wr_misc;
    logic wr_meas;
    logic wr_status;
    logic wr_mask;
    logic wr_pinsel;
    logic rd_event;

    // ----------------------------------------------------------------
    // Bus front end
    // ----------------------------------------------------------------
    pif_wb_slave #(
        .ADDR_W(ADDR_W)
    ) u_slave (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .wb_cyc(wb_cyc),
        .wb_stb(wb_stb),
        .wb_we(wb_we),
        .wb_adr(wb_adr),
        .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack),
        .bus(bus.slave)
    );

    // Per-register write strobes; misses are dropped silently
    assign wr_cap = bus.wr & bus.hit & (bus.idx == `PIF_IDX_CAPTURE);
    assign wr_misc = bus.wr & bus.hit & (bus.idx == `PIF_IDX_MISC);
    assign wr_meas = bus.wr & bus.hit & (bus.idx == `PIF_IDX_MEASURE);
    assign wr_status = bus.wr & bus.hit & (bus.idx == `PIF_IDX_STATUS);
    assign wr_mask = bus.wr & bus.hit & (bus.idx == `PIF_IDX_MASK);
    assign wr_pinsel = bus.wr & bus.hit & (bus.idx == `PIF_IDX_PINSEL);
    assign rd_event = bus.rd & bus.hit & (bus.idx == `PIF_IDX_EVENT);

    // ----------------------------------------------------------------
    // Enable registers
    // ----------------------------------------------------------------
    // Capture unit enables; unused top bits forced to zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            capture_irq_enable_r <= `PIF_RST_BYTE;
        end else if (ce && wr_cap) begin
            capture_irq_enable_r <= bus.wdata & `PIF_CAP_MASK;
        end
    end

    // Scanner, checksum, memory write, oscillator and waveform enables
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            misc_irq_enable_r <= `PIF_RST_BYTE;
        end else if (ce && wr_misc) begin
            misc_irq_enable_r <= bus.wdata & `PIF_MISC_MASK;
        end
    end

    // Measure timer 2 in bits 5..3, timer 1 in bits 2..0
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            measure_timer_irq_enable_r <= `PIF_RST_BYTE;
        end else if (ce && wr_meas) begin
            measure_timer_irq_enable_r <= bus.wdata & `PIF_MEAS_MASK;
        end
    end

    // ----------------------------------------------------------------
    // External pin selection and event detection
    // ----------------------------------------------------------------
    // Pin select register keeps the low SEL_W bits; stored values beyond the pin count alias to pin 0
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            external_pin_select_r <= '0;
        end else if (ce && wr_pinsel) begin
            external_pin_select_r <= bus.wdata[SEL_W-1:0];
        end
    end

    // Compared as int: a SEL_W-bit copy of PIN_N would wrap to zero
    assign pin_now = (int'(external_pin_select_r) < PIN_N) ?
                     gpio[external_pin_select_r] : gpio[0];

    // Previous level of the chosen pin; a reselect may fake one edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_prev_r <= 1'b0;
        end else if (ce) begin
            pin_prev_r <= pin_now;
        end
    end

    // Edge polarity comes from the core's control register
    assign ext_event = ext_rising_edge ? (pin_now & ~pin_prev_r)
                                       : (~pin_now & pin_prev_r);

    // ----------------------------------------------------------------
    // Core status flags
    // ----------------------------------------------------------------
    // Summary follows the port flags; bus writes cannot touch it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            change_notify_summary_flag_r <= 1'b0;
            chg_prev_r <= 1'b0;
        end else if (ce) begin
            change_notify_summary_flag_r <= |port_change_flags;
            chg_prev_r <= change_notify_summary_flag_r;
        end
    end

    // Bit 1 is the timer0 flag, bit 0 the external pin flag
    assign core_wdata = {bus.wdata[`PIF_ST_TMR0_BIT],
                         bus.wdata[`PIF_ST_EXT_BIT]};

    // Hardware set wins over a clearing write in the same cycle
    pif_sticky #(
        .W(2)
    ) u_core_flags (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .set({timer0_overflow, ext_event}),
        .load(wr_status),
        .d(core_wdata),
        .q(core_flags)
    );

    // Assemble the status byte; unused bits stay zero
    always_comb begin
        status_v = `PIF_RST_BYTE;
        status_v[`PIF_ST_TMR0_BIT] = core_flags[1];
        status_v[`PIF_ST_CHG_BIT] = change_notify_summary_flag_r;
        status_v[`PIF_ST_EXT_BIT] = core_flags[0];
    end

    // ----------------------------------------------------------------
    // Peripheral request toward the core
    // ----------------------------------------------------------------
    // Global enable peripheral_irq_enable gates the request here, ahead of the register
    assign req_nxt = peripheral_irq_enable &
                     (|(capture_flags & capture_irq_enable_r) |
                      |(misc_flags & misc_irq_enable_r) |
                      |(measure_flags & measure_timer_irq_enable_r));

    // Registered so the request is glitch free at the core
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            peripheral_irq_req_r <= 1'b0;
            req_prev_r <= 1'b0;
        end else if (ce) begin
            peripheral_irq_req_r <= req_nxt;
            req_prev_r <= peripheral_irq_req_r;
        end
    end

    // ----------------------------------------------------------------
    // Sticky events, mask and interrupt output
    // ----------------------------------------------------------------
    always_comb begin
        event_set = `PIF_EV_RST;
        event_set[`PIF_EV_TMR0] = timer0_overflow;
        event_set[`PIF_EV_EXT] = ext_event;
        event_set[`PIF_EV_CHG] = change_notify_summary_flag_r & ~chg_prev_r;
        event_set[`PIF_EV_REQ] = peripheral_irq_req_r & ~req_prev_r;
    end

    // Read clears; an event in the reading cycle stays pending
    pif_sticky #(
        .W(`PIF_EV_W)
    ) u_events (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .set(event_set),
        .load(rd_event),
        .d(`PIF_EV_RST),
        .q(event_status)
    );

    // Mask register, same layout as the event status
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_mask_r <= `PIF_EV_RST;
        end else if (ce && wr_mask) begin
            irq_mask_r <= bus.wdata[`PIF_EV_W-1:0];
        end
    end

    // Level interrupt, one cycle behind the status it reflects
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= |(event_status & irq_mask_r);
        end
    end

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    // Unmapped offsets read as zero
    always_comb begin
        rdata_nxt = `PIF_RST_BYTE;
        if (bus.hit) begin
            case (bus.idx)
                `PIF_IDX_CAPTURE: rdata_nxt = capture_irq_enable_r;
                `PIF_IDX_MISC: rdata_nxt = misc_irq_enable_r;
                `PIF_IDX_MEASURE: rdata_nxt = measure_timer_irq_enable_r;
                `PIF_IDX_STATUS: rdata_nxt = status_v;
                `PIF_IDX_EVENT: begin
                    rdata_nxt[`PIF_EV_W-1:0] = event_status;
                end
                `PIF_IDX_MASK: begin
                    rdata_nxt[`PIF_EV_W-1:0] = irq_mask_r;
                end
                `PIF_IDX_PINSEL: begin
                    rdata_nxt[SEL_W-1:0] = external_pin_select_r;
                end
                default: rdata_nxt = `PIF_RST_BYTE;
            endcase
        end
    end

    assign bus.rdata = rdata_nxt;

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign capture_irq_enable = capture_irq_enable_r;
    assign misc_irq_enable = misc_irq_enable_r;
    assign measure_timer_irq_enable = measure_timer_irq_enable_r;
    assign core_irq_status = status_v;
    assign peripheral_irq_req = peripheral_irq_req_r;
    assign irq = irq_r;
endmodule

// ===== hw/pif_irq_consts.svh
// Register map, field layout and reset values of the interrupt flag block
`ifndef PIF_IRQ_CONSTS_SVH
`define PIF_IRQ_CONSTS_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define PIF_DATA_W 32
`define PIF_REG_W 8
`define PIF_IDX_W 3
`define PIF_IDX_LSB 2
`define PIF_IDX_MSB 4

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PIF_IDX_CAPTURE 3'h0
`define PIF_IDX_MISC 3'h1
`define PIF_IDX_MEASURE 3'h2
`define PIF_IDX_STATUS 3'h3
`define PIF_IDX_EVENT 3'h4
`define PIF_IDX_MASK 3'h5
`define PIF_IDX_PINSEL 3'h6

// ----------------------------------------------------------------
// Implemented bits and reset values
// ----------------------------------------------------------------
`define PIF_CAP_MASK 8'h1F
`define PIF_MISC_MASK 8'hF7
`define PIF_MEAS_MASK 8'h3F
`define PIF_RST_BYTE 8'h00
`define PIF_ST_TMR0_BIT 5
`define PIF_ST_CHG_BIT 4
`define PIF_ST_EXT_BIT 0

// ----------------------------------------------------------------
// Sticky event status and mask layout
// ----------------------------------------------------------------
`define PIF_EV_W 4
`define PIF_EV_TMR0 0
`define PIF_EV_EXT 1
`define PIF_EV_CHG 2
`define PIF_EV_REQ 3
`define PIF_EV_RST 4'h0

`endif

// ===== hw/pif_pkg.sv
// Shared types of the interrupt flag block
package pif_pkg;
    typedef logic [7:0] pif_byte_type;
    typedef logic [2:0] pif_idx_type;
    typedef logic [3:0] pif_event_type;
endpackage

// ===== hw/pif_reg_if.sv
// Register access strobes between the bus slave and the register file
`timescale 1ns/100ps
interface pif_reg_if;
    logic wr;
    logic rd;
    logic hit;
    pif_pkg::pif_idx_type idx;
    pif_pkg::pif_byte_type wdata;
    pif_pkg::pif_byte_type rdata;

    modport slave (
        output wr,
        output rd,
        output hit,
        output idx,
        output wdata,
        input rdata
    );

    modport regs (
        input wr,
        input rd,
        input hit,
        input idx,
        input wdata,
        output rdata
    );
endinterface

// ===== hw/pif_sticky.sv
// Sticky flag vector: hardware set wins over a software load
`timescale 1ns/100ps
`include "pif_irq_consts.svh"
module pif_sticky #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [W-1:0] set,
    input wire logic load,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] q_r;

    // Set term is ORed last so a coincident clear never loses an event
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_r <= '0;
        end else if (ce) begin
            q_r <= set | (load ? d : q_r);
        end
    end

    assign q = q_r;
endmodule

// ===== hw/pif_wb_slave.sv
// Classic Wishbone slave front end, registered ack one cycle after each access
`timescale 1ns/100ps
`include "pif_irq_consts.svh"
module pif_wb_slave #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADDR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [`PIF_DATA_W-1:0] wb_dat_w,
    output logic [`PIF_DATA_W-1:0] wb_dat_r,
    output logic wb_ack,
    pif_reg_if.slave bus
);
    logic ack_r;
    logic [`PIF_DATA_W-1:0] dat_r;
    logic take;

    // A request is taken once; ack_r masks the cycle it is answered in
    assign take = wb_cyc & wb_stb & ~ack_r & ce;
    assign bus.wr = take & wb_we & wb_sel[0];
    assign bus.rd = take & ~wb_we;
    assign bus.idx = wb_adr[`PIF_IDX_MSB:`PIF_IDX_LSB];
    assign bus.wdata = wb_dat_w[`PIF_REG_W-1:0];
    // Upper address bits must be zero, otherwise the access misses
    assign bus.hit = (wb_adr[ADDR_W-1:`PIF_IDX_MSB+1] == '0);

    // Acknowledge every access, mapped or not, one cycle after it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
        end else if (ce) begin
            ack_r <= take;
        end
    end

    // Read data held only in the ack cycle, zero otherwise
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dat_r <= '0;
        end else if (ce) begin
            if (bus.rd) begin
                dat_r <= {{(`PIF_DATA_W-`PIF_REG_W){1'b0}}, bus.rdata};
            end else begin
                dat_r <= '0;
            end
        end
    end

    assign wb_ack = ack_r;
    assign wb_dat_r = dat_r;
endmodule

// ===== test/pif_irq_sva.sv
// Concurrent checks on the ports of the interrupt flag block
`timescale 1ns/100ps
module pif_irq_sva #(
    parameter int ADDR_W = 8,
    parameter int PORTS = 5,
    parameter int PORT_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADDR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic wb_ack,
    input wire logic timer0_overflow,
    input wire logic [PORTS*PORT_W-1:0] port_change_flags,
    input wire logic peripheral_irq_enable,
    input wire logic [7:0] capture_flags,
    input wire logic [7:0] misc_flags,
    input wire logic [7:0] measure_flags,
    input wire logic [7:0] capture_irq_enable,
    input wire logic [7:0] misc_irq_enable,
    input wire logic [7:0] measure_timer_irq_enable,
    input wire logic [7:0] core_irq_status,
    input wire logic peripheral_irq_req
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // A request is taken only while ack is low, so ack cannot stick
    wire logic take = ce && wb_cyc && wb_stb && !wb_ack;
    AST_ACK_NEXT: assert property (take |=> wb_ack)
        else $error("ack missing after request");
    AST_ACK_ONE: assert property (ce && wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    AST_CAP_TOP: assert property (capture_irq_enable[7:5] == 3'h0)
        else $error("capture enable top bits set");
    AST_MISC_GAP: assert property (misc_irq_enable[3] == 1'h0)
        else $error("misc enable bit 3 set");
    AST_MEAS_TOP: assert property (measure_timer_irq_enable[7:6] == 2'h0)
        else $error("measure enable top bits set");
    AST_ST_GAP: assert property (core_irq_status[7:6] == 2'h0 &&
        core_irq_status[3:1] == 3'h0) else $error("status gap bits set");
    AST_CAP_WR: assert property (take && wb_we && wb_sel[0] &&
        wb_adr == 'h0 |=> capture_irq_enable == ($past(wb_dat_w[7:0]) &
        8'h1F)) else $error("capture enable write lost");
    AST_T0_SET: assert property (ce && timer0_overflow
        |=> core_irq_status[5]) else $error("overflow flag not set");
    AST_T0_HOLD: assert property (ce && core_irq_status[5] &&
        !(take && wb_we && wb_adr == 'hC) |=> core_irq_status[5])
        else $error("overflow flag dropped by itself");
    AST_CHG_OR: assert property (ce |=> core_irq_status[4] ==
        $past(|port_change_flags)) else $error("summary not port OR");
    AST_PREQ: assert property (ce |=> peripheral_irq_req ==
        $past(peripheral_irq_enable &&
        |((capture_flags & capture_irq_enable) | (misc_flags &
        misc_irq_enable) | (measure_flags & measure_timer_irq_enable))))
        else $error("peripheral request wrong");
endmodule
bind pif_irq pif_irq_sva #(.ADDR_W(ADDR_W), .PORTS(PORTS), .PORT_W(PORT_W))
    i_pif_irq_sva (.clk, .rst_b, .ce, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
    .wb_sel, .wb_dat_w, .wb_ack, .timer0_overflow, .port_change_flags,
    .peripheral_irq_enable, .capture_flags, .misc_flags, .measure_flags,
    .capture_irq_enable, .misc_irq_enable, .measure_timer_irq_enable,
    .core_irq_status, .peripheral_irq_req);

// ===== test/pif_irq_test.sv
// Self-checking bench of the interrupt enable and flag block
`timescale 1ns/100ps
module pif_irq_test;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic ce = 1'h1;
    logic wb_cyc = 1'h0;
    logic wb_stb = 1'h0;
    logic wb_we = 1'h0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic t0_go = 1'h0;
    logic [4:0] port_on = 5'h00;
    logic timer0_overflow;
    logic [39:0] port_change_flags;
    logic [7:0] gpio = 8'h00;
    logic ext_rising_edge = 1'h1;
    logic peripheral_irq_enable = 1'h0;
    logic [7:0] capture_flags = 8'h00;
    logic [7:0] misc_flags = 8'h00;
    logic [7:0] measure_flags = 8'h00;
    logic [7:0] capture_irq_enable;
    logic [7:0] misc_irq_enable;
    logic [7:0] measure_timer_irq_enable;
    logic [7:0] core_irq_status;
    logic peripheral_irq_req;
    logic irq;
    logic [31:0] rd;
    logic [7:0] msk [3] = '{8'h1F, 8'hF7, 8'h3F};
    logic [7:0] pat [3] = '{8'hFF, 8'h55, 8'hAA};
    int n_fail = 0;
    int cmp_count = 0;
    int cyc_n = 0;

    pif_irq i_pif_irq (.clk, .rst_b, .ce, .wb_cyc, .wb_stb, .wb_we,
        .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .timer0_overflow,
        .gpio, .ext_rising_edge, .port_change_flags, .peripheral_irq_enable,
        .capture_flags, .misc_flags, .measure_flags, .capture_irq_enable,
        .misc_irq_enable, .measure_timer_irq_enable, .core_irq_status,
        .peripheral_irq_req, .irq);
    pif_src_model i_pif_src_model (.clk, .rst_b, .t0_go, .port_on,
        .timer0_overflow, .port_change_flags);

    // ----------------------------------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------------------------------
    always #4 clk = ~clk;
    // The whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Request held until ack is sampled high; the idle cycle comes first
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge clk);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= 4'hF;
        wb_dat_w <= {24'h0, d};
        @(posedge clk);
        while (wb_ack !== 1'h1) @(posedge clk);
        rd = wb_dat_r;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we <= 1'h0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        bus(1'h0, a, 8'h00);
        chk($sformatf("reg %0h", a), {24'h0, e}, rd);
    endtask
    task automatic pulse_t0();
        t0_go <= 1'h1;
        @(posedge clk);
        t0_go <= 1'h0;
        tick(3);
    endtask
    task automatic chk_reset();
        for (int i = 0; i < 4; i++) begin
            rdc(8'(4 * i), 8'h00);
        end
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        tick(12);
        rst_b <= 1'h1;
        chk_reset();
        // Bit patterns keep only implemented enable bits
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 3; j++) begin
                wr_loop: bus(1'h1, 8'(4 * i), pat[j]);
                rdc(8'(4 * i), pat[j] & msk[i]);
            end
            bus(1'h1, 8'(4 * i), 8'h00);
        end
        // Unmapped words, also with an address bit above the index
        bus(1'h1, 8'h1C, 8'hFF);
        rdc(8'h1C, 8'h00);
        bus(1'h1, 8'h20, 8'hFF);
        rdc(8'h00, 8'h00);
        // Overflow flags with every enable off and stays until written
        pulse_t0();
        rdc(8'h0C, 8'h20);
        rdc(8'h0C, 8'h20);
        bus(1'h1, 8'h0C, 8'h00);
        rdc(8'h0C, 8'h00);
        bus(1'h1, 8'h0C, 8'hFF);
        rdc(8'h0C, 8'h21);
        // Reselecting the pin may flag once, so clear after it
        bus(1'h1, 8'h18, 8'h03);
        bus(1'h1, 8'h0C, 8'h00);
        gpio <= 8'h20;
        tick(3);
        rdc(8'h0C, 8'h00);
        gpio <= 8'h28;
        tick(3);
        rdc(8'h0C, 8'h01);
        bus(1'h1, 8'h0C, 8'h00);
        rdc(8'h0C, 8'h00);
        ext_rising_edge <= 1'h0;
        gpio <= 8'h20;
        tick(3);
        rdc(8'h0C, 8'h01);
        bus(1'h1, 8'h0C, 8'h00);
        // Summary follows the OR of port flags; writing it does nothing
        port_on <= 5'h10;
        tick(3);
        rdc(8'h0C, 8'h10);
        bus(1'h1, 8'h0C, 8'h00);
        rdc(8'h0C, 8'h10);
        chk("status", 32'h10, 32'(core_irq_status));
        port_on <= 5'h11;
        tick(2);
        port_on <= 5'h01;
        tick(3);
        rdc(8'h0C, 8'h10);
        port_on <= 5'h00;
        tick(3);
        rdc(8'h0C, 8'h00);
        // Clock enable low freezes the flags: this pulse is lost
        ce <= 1'h0;
        pulse_t0();
        ce <= 1'h1;
        rdc(8'h0C, 8'h00);
        // Flags in unimplemented misc and measure positions, or behind the off capture enable, request nothing
        capture_flags <= 8'h04;
        misc_flags <= 8'h08;
        measure_flags <= 8'hC0;
        bus(1'h1, 8'h04, 8'hFF);
        bus(1'h1, 8'h08, 8'hFF);
        peripheral_irq_enable <= 1'h1;
        tick(3);
        chk("req", 32'h0, 32'(peripheral_irq_req));
        chk("misc_en", 32'hF7, 32'(misc_irq_enable));
        chk("meas_en", 32'h3F, 32'(measure_timer_irq_enable));
        bus(1'h1, 8'h00, 8'h04);
        tick(3);
        chk("cap_en", 32'h04, 32'(capture_irq_enable));
        chk("req", 32'h1, 32'(peripheral_irq_req));
        peripheral_irq_enable <= 1'h0;
        tick(3);
        chk("req", 32'h0, 32'(peripheral_irq_req));
        capture_flags <= 8'h00;
        // Event status behind the mask drives irq; a read clears it
        rdc(8'h10, 8'h0F);
        bus(1'h1, 8'h14, 8'h01);
        pulse_t0();
        chk("irq", 32'h1, 32'(irq));
        rdc(8'h10, 8'h01);
        tick(3);
        chk("irq", 32'h0, 32'(irq));
        bus(1'h1, 8'h14, 8'h00);
        pulse_t0();
        chk("irq", 32'h0, 32'(irq));
        rdc(8'h0C, 8'h20);
        // A second reset clears everything again
        rst_b <= 1'h0;
        tick(2);
        rst_b <= 1'h1;
        chk_reset();
        conclude();
    end
endmodule

// ===== test/pif_src_model.sv
// Event source model: timer overflow pulses and per-port change flags
`timescale 1ns/100ps
module pif_src_model #(
    parameter int PORTS = 5,
    parameter int PORT_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic t0_go,
    input wire logic [PORTS-1:0] port_on,
    output logic timer0_overflow,
    output logic [PORTS*PORT_W-1:0] port_change_flags
);
    // ----------------------------------------------------------------
    // Sources
    // ----------------------------------------------------------------
    // One overflow pulse per requested cycle, as a real timer rolls over
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timer0_overflow <= 1'h0;
        end else begin
            timer0_overflow <= t0_go;
        end
    end
    // Each port holds one pin flag; dropping it is the only way
    // software can clear the summary
    always_comb begin
        port_change_flags = '0;
        for (int i = 0; i < PORTS; i++) begin
            port_change_flags[i*PORT_W+(i%PORT_W)] = port_on[i];
        end
    end
endmodule
